// file: design/sleep_controller.sv
// sleep mode controller: entry, clock gating, wake sources and wake-up latency
`timescale 1ns/1ns
`default_nettype none
// Operation
// - one active mode plus three sleep modes
// - mode field bits 2:1, enable bit 0
// - sleep halts cpu and gates excluded domains
// - enabled interrupt wakes; resume after sleep
// - any reset leaves sleep
// - debug break wakes to active mode
// - running debug leaves sleep unaffected
// - idle stops cpu only, any interrupt wakes
// - standby peripherals follow run-in-standby
// - standby wake source list with conditions
// - power down keeps watchdog and timer only
// - wake takes six clocks plus oscillator start
// - oscillator start only after standby/power down
// - power down clocks only low-power sources
// - brownout ready gates wake when configured
// - runs on the peripheral clock
module sleep_controller (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic control_a_we,
  input wire logic [2:0] control_a_wdata,
  output logic [2:0] control_a_rdata,
  input wire logic sleep_instr,
  input wire logic debug_break,
  input wire logic pin_irq,
  input wire logic twi_addr_match_irq,
  input wire logic periodic_timer_irq,
  input wire logic timer_b_irq,
  input wire logic uart_sof_irq,
  input wire logic rtc_irq,
  input wire logic adc_window_irq,
  input wire logic other_irq,
  input wire logic uart_run_in_standby,
  input wire logic rtc_run_in_standby,
  input wire logic adc_run_in_standby,
  input wire logic main_osc_run_in_standby,
  input wire logic main_osc_ready,
  input wire logic low_power_osc_needed,
  input wire logic [1:0] brownout_config_fuse,
  input wire logic brownout_ready,
  output logic cpu_halt,
  output logic cpu_clk_en,
  output logic peripheral_clk_en,
  output logic rtc_clk_en,
  output logic adc_clk_en,
  output logic uart_clk_en,
  output logic watchdog_clk_en,
  output logic periodic_timer_clk_en,
  output logic main_osc_en,
  output logic low_power_osc_en,
  output logic sleeping,
  output logic [1:0] sleep_mode
);
  // one awake state, others asleep or waking
  typedef enum logic [3:0] {
    ST_ACTIVE = 4'h1,
    ST_SLEEP = 4'h2,
    ST_OSC = 4'h4,
    ST_COUNT = 4'h8
  } state_t;

  state_t state_q, state_d;
  logic [2:0] ctrl_q;
  logic [1:0] mode_q;
  logic [sleep_pkg::WAKE_CNT_W-1:0] cnt_q, cnt_d;

  wire logic [1:0] sel_mode = ctrl_q[sleep_pkg::MODE_MSB:sleep_pkg::MODE_LSB];
  wire logic sel_enable = ctrl_q[sleep_pkg::ENABLE_BIT];
  wire logic sel_legal = sel_mode != 2'h3;
  wire logic in_idle = mode_q == sleep_pkg::MODE_IDLE;
  wire logic in_stby = mode_q == sleep_pkg::MODE_STANDBY;
  wire logic in_power_down_mode = mode_q == sleep_pkg::MODE_POWER_DOWN;
  // standby sources, some gated by run-in-standby
  wire logic wake_stby = pin_irq | twi_addr_match_irq | periodic_timer_irq | timer_b_irq
    | (uart_sof_irq & uart_run_in_standby) | (rtc_irq & rtc_run_in_standby)
    | (adc_window_irq & adc_run_in_standby);
  wire logic wake_power_down_mode = pin_irq | twi_addr_match_irq | periodic_timer_irq;
  wire logic wake_idle = wake_stby | uart_sof_irq | rtc_irq | adc_window_irq | other_irq;
  // only interrupts enabled upstream reach these inputs
  wire logic wake_irq = (in_idle & wake_idle) | (in_stby & wake_stby) | (in_power_down_mode & wake_power_down_mode);
  // only a break matters, running debug ignored
  // debug break wakes even without an interrupt
  wire logic wake_req = wake_irq | debug_break;
  // main oscillator stopped in power down, and in standby unless kept running
  wire logic osc_stopped = in_power_down_mode | (in_stby & ~main_osc_run_in_standby);
  wire logic bod_hold = brownout_config_fuse == sleep_pkg::BOD_WAIT_FOR_READY;
  wire logic count_done = cnt_q == sleep_pkg::WAKE_CNT_ONE;
  wire logic release_ok = count_done & (~bod_hold | brownout_ready);
  wire logic sleep_next = state_d != ST_ACTIVE;
  wire logic [1:0] mode_next = (state_q == ST_ACTIVE) ? sel_mode : mode_q;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      ST_ACTIVE:
      begin
        // sleep only with enable and legal mode
        if (sleep_instr && sel_enable && sel_legal)
          state_d = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        if (wake_req)
        begin
          // six clocks, after oscillator start if stopped
          cnt_d = sleep_pkg::WAKE_CNT_LOAD;
          state_d = (osc_stopped && !main_osc_ready) ? ST_OSC : ST_COUNT;
        end
      end
      ST_OSC:
      begin
        cnt_d = sleep_pkg::WAKE_CNT_LOAD;
        if (main_osc_ready)
          state_d = ST_COUNT;
      end
      ST_COUNT:
      begin
        if (cnt_q != sleep_pkg::WAKE_CNT_ONE)
          cnt_d = cnt_q - sleep_pkg::WAKE_CNT_ONE;
        if (release_ok)
        begin
          state_d = ST_ACTIVE;
          cnt_d = sleep_pkg::WAKE_CNT_ZERO;
        end
      end
      default:
        state_d = ST_ACTIVE;
    endcase
  end

  // any reset returns to active at once, asynchronously
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_ACTIVE;
      cnt_q <= sleep_pkg::WAKE_CNT_ZERO;
      mode_q <= sleep_pkg::MODE_IDLE;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      mode_q <= mode_next;
    end
  end

  // control register, writable only while awake
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= sleep_pkg::CONTROL_A_RESET;
    else if (control_a_we && state_q == ST_ACTIVE)
      ctrl_q <= control_a_wdata;
  end

  wire logic awake_n = ~sleep_next;
  wire logic idle_n = mode_next == sleep_pkg::MODE_IDLE;
  wire logic stby_n = mode_next == sleep_pkg::MODE_STANDBY;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_halt <= 1'b0;
      cpu_clk_en <= 1'b1;
      peripheral_clk_en <= 1'b1;
      rtc_clk_en <= 1'b1;
      adc_clk_en <= 1'b1;
      uart_clk_en <= 1'b1;
      watchdog_clk_en <= 1'b1;
      periodic_timer_clk_en <= 1'b1;
      main_osc_en <= 1'b1;
      low_power_osc_en <= 1'b1;
      sleeping <= 1'b0;
      sleep_mode <= sleep_pkg::MODE_IDLE;
      control_a_rdata <= sleep_pkg::CONTROL_A_RESET;
    end
    else
    begin
      cpu_halt <= sleep_next;
      cpu_clk_en <= awake_n;
      peripheral_clk_en <= awake_n | idle_n;
      rtc_clk_en <= awake_n | idle_n | (stby_n & rtc_run_in_standby);
      adc_clk_en <= awake_n | idle_n | (stby_n & adc_run_in_standby);
      uart_clk_en <= awake_n | idle_n | (stby_n & uart_run_in_standby);
      watchdog_clk_en <= 1'b1;
      periodic_timer_clk_en <= 1'b1;
      // main clock must keep running through the fixed count, not only the start-up wait
      main_osc_en <= awake_n | idle_n | (stby_n & main_osc_run_in_standby) | (state_d == ST_OSC)
        | (state_d == ST_COUNT);
      low_power_osc_en <= awake_n | ~(mode_next == sleep_pkg::MODE_POWER_DOWN) | low_power_osc_needed;
      sleeping <= sleep_next;
      sleep_mode <= mode_next;
      control_a_rdata <= (control_a_we && state_q == ST_ACTIVE) ? control_a_wdata : ctrl_q;
    end
  end

  no_sleep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_ACTIVE && sleep_instr && !sel_enable) |=> !sleeping)
    else $error("slept with enable clear");
  // wake from idle lands after six clocks
  idle_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_SLEEP && in_idle && wake_req && !bod_hold) |-> ##7 !cpu_halt)
    else $error("idle wake latency wrong");
  min_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_SLEEP && wake_req) |=> cpu_halt [*5])
    else $error("wake released early");
  bod_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_COUNT && bod_hold && !brownout_ready) |=> cpu_halt)
    else $error("released before brownout ready");
  cpu_clk_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q != ST_ACTIVE) |-> !cpu_clk_en && sleeping)
    else $error("cpu clock on in sleep");
  power_down_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sleeping && sleep_mode == sleep_pkg::MODE_POWER_DOWN) |-> !peripheral_clk_en && !adc_clk_en)
    else $error("peripherals running in power down");
  idle_per_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sleeping && sleep_mode == sleep_pkg::MODE_IDLE) |-> peripheral_clk_en)
    else $error("peripheral clock off in idle");
  // debug break leaves sleep within bound
  dbg_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_SLEEP && debug_break && !osc_stopped && !bod_hold) |-> ##[1:8] !sleeping)
    else $error("debug break did not wake");
  reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    sleeping |-> sleep_mode != 2'h3)
    else $error("reserved mode entered");
endmodule // sleep_controller
`default_nettype wire

// file: pkg/sleep_pkg.sv
// shared constants for the sleep mode controller
package sleep_pkg;
  localparam int ENABLE_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam int MODE_MSB = 2;
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_STANDBY = 2'h1;
  localparam logic [1:0] MODE_POWER_DOWN = 2'h2;
  localparam logic [2:0] CONTROL_A_RESET = 3'h0;
  localparam logic [1:0] BOD_WAIT_FOR_READY = 2'h3;
  localparam int WAKE_CYCLES = 6;
  localparam int WAKE_CNT_W = 3;
  localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_ZERO = 3'h0;
  localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_ONE = 3'h1;
  localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_LOAD = 3'(WAKE_CYCLES);
endpackage

// file: verification/osc_model.sv
// main oscillator start-up model on the clock controller side
`timescale 1ns/1ns
`default_nettype none
module osc_model #(parameter int START = 4) (
  input wire logic clk,
  input wire logic en,
  output logic ready
);
  int cnt = 0;
  always @(posedge clk)
  begin
    cnt <= en ? ((cnt < START) ? cnt + 1 : cnt) : 0;
    ready <= en && (cnt >= START - 1);
  end
endmodule // osc_model
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the sleep mode controller
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, slp = 1'b0, dbg = 1'b0, bod_rdy = 1'b1, lp_need = 1'b0;
  logic osc_run = 1'b0, osc_rdy, sl, halt, cpu_en, per_en, rtc_en, adc_en, uart_en, wdt_en, pit_en, osc_en, lp_en;
  logic [2:0] wd = 3'h0, rsb = 3'h0, rd;
  logic [7:0] irq = 8'h00;
  logic [1:0] fuse = 2'h0, md;
  int errors = 0, checked = 0, n;
  sleep_controller u_dut (.clk(clk), .rst_n(rst_n), .control_a_we(we), .control_a_wdata(wd),
    .control_a_rdata(rd), .sleep_instr(slp), .debug_break(dbg), .pin_irq(irq[7]), .twi_addr_match_irq(irq[6]),
    .periodic_timer_irq(irq[5]), .timer_b_irq(irq[4]), .uart_sof_irq(irq[3]), .rtc_irq(irq[2]),
    .adc_window_irq(irq[1]), .other_irq(irq[0]), .uart_run_in_standby(rsb[2]), .rtc_run_in_standby(rsb[1]),
    .adc_run_in_standby(rsb[0]), .main_osc_run_in_standby(osc_run), .main_osc_ready(osc_rdy),
    .low_power_osc_needed(lp_need), .brownout_config_fuse(fuse), .brownout_ready(bod_rdy), .cpu_halt(halt),
    .cpu_clk_en(cpu_en), .peripheral_clk_en(per_en), .rtc_clk_en(rtc_en), .adc_clk_en(adc_en),
    .uart_clk_en(uart_en), .watchdog_clk_en(wdt_en), .periodic_timer_clk_en(pit_en), .main_osc_en(osc_en),
    .low_power_osc_en(lp_en), .sleeping(sl), .sleep_mode(md));
  osc_model u_osc (.clk(clk), .en(osc_en), .ready(osc_rdy));
  initial
  begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // mode and enable first, then the sleep instruction
  task automatic go_sleep(input logic [2:0] v);
    @(negedge clk) we = 1'b1;
    wd = v;
    @(negedge clk) we = 1'b0;
    slp = 1'b1;
    @(negedge clk) slp = 1'b0;
  endtask
  // only enabled, pending interrupts are poked
  task automatic poke(input logic [7:0] m);
    @(negedge clk) irq = m;
    @(negedge clk) irq = 8'h00;
  endtask
  // bounded: a stuck sleep ends the run
  task automatic wake_wait();
    n = 0;
    while (sl !== 1'b0 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (sl !== 1'b0)
    begin
      errors++;
      give_verdict();
    end
  endtask
  task automatic s_noen();
    logic [2:0] v[2] = '{3'h4, 3'h7};
    foreach (v[i])
    begin
      go_sleep(v[i]);
      chk(8'(rd), 8'(v[i]));
      chk(8'(sl), 8'h00);
    end
  endtask
  task automatic s_idle();
    go_sleep(3'h1);
    chk({2'h0, sl, halt, cpu_en, per_en, wdt_en, pit_en}, 8'h37);
    poke(8'h01);
    wake_wait();
    chk(8'(n), 8'(sleep_pkg::WAKE_CYCLES));
    chk(8'(cpu_en), 8'h01);
    go_sleep(3'h1);
    dbg = 1'b1;
    @(negedge clk);
    dbg = 1'b0;
    wake_wait();
    chk(8'(n), 8'(sleep_pkg::WAKE_CYCLES));
  endtask
  task automatic s_stby();
    rsb = 3'h4;
    go_sleep(3'h3);
    chk({1'b0, per_en, uart_en, rtc_en, wdt_en, osc_en, md}, 8'h29);
    poke(8'h05);
    repeat (10) @(negedge clk);
    chk(8'(sl), 8'h01);
    poke(8'h10);
    wake_wait();
    chk(8'(n > 7), 8'h01);
    osc_run = 1'b1;
    go_sleep(3'h3);
    chk(8'(osc_en), 8'h01);
    poke(8'h80);
    wake_wait();
    chk(8'(n), 8'(sleep_pkg::WAKE_CYCLES));
    osc_run = 1'b0;
  endtask
  task automatic s_power_down_mode();
    lp_need = 1'b1;
    rsb = 3'h7;
    go_sleep(3'h5);
    chk({1'b0, rtc_en, adc_en, uart_en, wdt_en, pit_en, lp_en, osc_en}, 8'h0E);
    poke(8'h1F);
    repeat (10) @(negedge clk);
    chk(8'(sl), 8'h01);
    dbg = 1'b1;
    wake_wait();
    dbg = 1'b0;
    chk(8'(sl), 8'h00);
  endtask
  task automatic s_bod();
    fuse = 2'h3;
    bod_rdy = 1'b0;
    go_sleep(3'h1);
    poke(8'h80);
    repeat (20) @(negedge clk);
    chk(8'(sl), 8'h01);
    bod_rdy = 1'b1;
    wake_wait();
    chk(8'(n <= 3), 8'h01);
    go_sleep(3'h1);
    poke(8'h80);
    wake_wait();
    chk(8'(n), 8'(sleep_pkg::WAKE_CYCLES));
    fuse = 2'h0;
  endtask
  task automatic s_rst();
    go_sleep(3'h3);
    @(negedge clk) rst_n = 1'b0;
    @(negedge clk) chk({3'h0, sl, halt, rd}, 8'h00);
    rst_n = 1'b1;
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk({1'b0, rd, sl, cpu_en, per_en, osc_en}, 8'h07);
    s_noen();
    s_idle();
    s_stby();
    s_power_down_mode();
    s_bod();
    s_rst();
    give_verdict();
  end
endmodule // tb
`default_nettype wire
